/* File: scv_defines.svh */
// Purpose: Constants of the analog input scaling curve unit
// Assumes: 100 MHz sys_clk, register words of 32 bits
// Notes:   Values are signed fixed point with SCV_FRAC fractional bits
`ifndef SCV_DEFINES_SVH
`define SCV_DEFINES_SVH

`define SCV_FRAC          8
`define SCV_NPTS          20
`define SCV_CLK_NS        10
`define SCV_STEP_NS       5000000
`define SCV_STEP_CYCLES   (`SCV_STEP_NS / `SCV_CLK_NS)
`define SCV_STEP_MS       5

`define SCV_A_CTRL        8'h00
`define SCV_A_CYCLE       8'h04
`define SCV_A_TAU         8'h08
`define SCV_A_IN_MIN      8'h0C
`define SCV_A_IN_MAX      8'h10
`define SCV_A_PT_USED     8'h14
`define SCV_A_CURVE_IN    8'h18
`define SCV_A_CURVE_OUT   8'h1C
`define SCV_A_STATUS      8'h20
`define SCV_A_CLEAR       8'h24
`define SCV_A_IRQ_EN      8'h28
`define SCV_A_PT_X        8'h40
`define SCV_A_PT_Y        8'h90

`define SCV_B_FILT_EN     0
`define SCV_B_OOR_EN      1
`define SCV_B_MODE_LO     2

`define SCV_ST_OOR        0
`define SCV_ST_UPDATED    1
`define SCV_ST_LOST       2

`define SCV_RST_CYCLE     12'h01E
`define SCV_RST_TAU       32'h000003E8
`define SCV_RST_PT2_X     32'h00000100

`endif

/* File: scv_pkg.sv */
// Purpose: Types of the analog input scaling curve unit
// Assumes: Constants come from scv_defines.svh
// Notes:   Used as scv_pkg::name, never imported
`default_nettype none
package scv_pkg;
  typedef enum logic [1:0] {
    SCV_RND_FIXED,
    SCV_RND_FLOOR,
    SCV_RND_CEIL,
    SCV_RND_NEAREST
  } scv_mode_t;

  typedef enum {
    SCV_IDLE,
    SCV_ALPHA,
    SCV_ALPHA_W,
    SCV_FILT,
    SCV_SEARCH,
    SCV_INTERP,
    SCV_INTERP_W,
    SCV_ROUND
  } scv_state_t;
endpackage : scv_pkg
`default_nettype wire

/* File: scv_curve.sv */
// Purpose: Update-cycle sampling, filter, curve mapping and rounding of one analog input
// Assumes: meas_valid marks a fresh sample on meas_data; meas_lost is a level
// Notes:   One shared 64-cycle divider serves both the coefficient and the interpolation
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scv_defines.svh"
module scv_curve #(
  parameter int STEP_CYCLES = `SCV_STEP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        meas_valid,
  input  wire logic [31:0] meas_data,
  input  wire logic        meas_lost,
  output logic      [31:0] curve_in,
  output logic      [31:0] curve_out,
  output logic             out_valid,
  output logic             scaling_curve_out_of_range,
  output logic             irq
);
  localparam int NP = `SCV_NPTS;
  localparam int F  = `SCV_FRAC;

  logic [3:0]              ctrl_r;
  logic [11:0]             cycle_r;
  logic [31:0]             tau_r;
  logic signed [31:0]      in_min_r;
  logic signed [31:0]      in_max_r;
  logic [NP-1:0]           used_r;
  logic signed [31:0]      pt_x_r [NP];
  logic signed [31:0]      pt_y_r [NP];
  logic [2:0]              status_r;
  logic [2:0]              irq_en_r;
  logic [2:0]              st_set;
  logic [2:0]              st_clr;

  logic signed [31:0]      last_valid_r;
  logic                    lost_seen_r;
  logic signed [31:0]      curve_in_r;
  logic signed [31:0]      filt_r;
  logic                    primed_r;
  logic [16:0]             alpha_r;
  logic signed [31:0]      out_r;
  logic                    out_valid_r;
  logic                    oor_r;
  logic [31:0]             rdata_r;

  logic [19:0]             step_cnt_r;
  logic [11:0]             cyc_cnt_r;
  logic                    step_tick;
  logic                    upd_tick;

  scv_pkg::scv_state_t     state_r;
  logic [4:0]              scan_r;
  logic [4:0]              prev_r;
  logic [4:0]              lo_r;
  logic [4:0]              hi_r;
  logic                    found_r;
  logic signed [31:0]      interp_r;

  logic                    div_go;
  logic                    div_run_r;
  logic [6:0]              div_cnt_r;
  logic [63:0]             div_quo_r;
  logic [32:0]             div_rem_r;
  logic [31:0]             div_den_r;
  logic [63:0]             div_num;
  logic [31:0]             div_den;
  logic [32:0]             rem_sh;

  logic [31:0]             cyc_ms;
  logic signed [32:0]      f_diff;
  logic signed [50:0]      f_prod;
  logic signed [31:0]      filt_nxt;
  logic signed [32:0]      dx;
  logic signed [32:0]      dy;
  logic signed [32:0]      xo;
  logic signed [65:0]      ip_num;
  logic [63:0]             ip_mag;
  logic                    ip_neg;
  logic signed [31:0]      ip_q;
  logic signed [31:0]      rnd_add;
  logic signed [31:0]      rounded;
  scv_pkg::scv_mode_t      mode;

  assign mode = scv_pkg::scv_mode_t'(ctrl_r[`SCV_B_MODE_LO +: 2]);
  assign cyc_ms = 32'(cycle_r) * 32'(`SCV_STEP_MS);

  // Register writes; read-only words ignore writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_r   <= 4'h0;
      cycle_r  <= `SCV_RST_CYCLE;
      tau_r    <= `SCV_RST_TAU;
      in_min_r <= 32'h00000000;
      in_max_r <= 32'h00000000;
      used_r   <= '0;
      irq_en_r <= 3'h0;
      for (int k = 0; k < NP; k++) begin
        pt_x_r[k] <= (k == 1) ? `SCV_RST_PT2_X : 32'h00000000;
        pt_y_r[k] <= 32'h00000000;
      end
    end else if (wr) begin
      case (addr)
        `SCV_A_CTRL:    ctrl_r   <= wdata[3:0];
        `SCV_A_CYCLE:   cycle_r  <= (wdata[11:0] == 12'h000) ? 12'h001 : wdata[11:0];
        `SCV_A_TAU:     tau_r    <= wdata;
        `SCV_A_IN_MIN:  in_min_r <= wdata;
        `SCV_A_IN_MAX:  in_max_r <= wdata;
        `SCV_A_PT_USED: used_r   <= {wdata[NP-1:2], 2'b11};
        `SCV_A_IRQ_EN:  irq_en_r <= wdata[2:0];
        default: begin
          for (int k = 0; k < NP; k++) begin
            if (addr == 8'(`SCV_A_PT_X + 4 * k)) begin
              pt_x_r[k] <= wdata;
            end
            if (addr == 8'(`SCV_A_PT_Y + 4 * k)) begin
              pt_y_r[k] <= wdata;
            end
          end
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `SCV_A_CTRL:      rdata_r <= {28'h0000000, ctrl_r};
        `SCV_A_CYCLE:     rdata_r <= {20'h00000, cycle_r};
        `SCV_A_TAU:       rdata_r <= tau_r;
        `SCV_A_IN_MIN:    rdata_r <= in_min_r;
        `SCV_A_IN_MAX:    rdata_r <= in_max_r;
        `SCV_A_PT_USED:   rdata_r <= {12'h000, used_r};
        `SCV_A_CURVE_IN:  rdata_r <= curve_in_r;
        `SCV_A_CURVE_OUT: rdata_r <= out_r;
        `SCV_A_STATUS:    rdata_r <= {29'h00000000, status_r};
        `SCV_A_IRQ_EN:    rdata_r <= {29'h00000000, irq_en_r};
        default: begin
          rdata_r <= 32'h00000000;
          for (int k = 0; k < NP; k++) begin
            if (addr == 8'(`SCV_A_PT_X + 4 * k)) begin
              rdata_r <= pt_x_r[k];
            end
            if (addr == 8'(`SCV_A_PT_Y + 4 * k)) begin
              rdata_r <= pt_y_r[k];
            end
          end
        end
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  // Sticky status: a set in the same cycle as its clear wins
  assign st_clr = (wr && addr == `SCV_A_CLEAR) ? wdata[2:0] : 3'h0;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // 5 ms step enable, then the configured number of steps per update
  assign step_tick = (step_cnt_r == 20'(STEP_CYCLES - 1));
  assign upd_tick  = step_tick && (cyc_cnt_r >= cycle_r - 12'h001);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      step_cnt_r <= 20'h00000;
      cyc_cnt_r  <= 12'h000;
    end else begin
      step_cnt_r <= step_tick ? 20'h00000 : step_cnt_r + 20'h00001;
      if (upd_tick) begin
        cyc_cnt_r <= 12'h000;
      end else if (step_tick) begin
        cyc_cnt_r <= cyc_cnt_r + 12'h001;
      end
    end
  end

  // Only valid samples are kept, so a lost input freezes the last one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_valid_r <= 32'h00000000;
      lost_seen_r  <= 1'b0;
    end else begin
      if (meas_valid && !meas_lost) begin
        last_valid_r <= meas_data;
      end
      if (upd_tick) begin
        lost_seen_r <= meas_lost;
      end else if (meas_lost) begin
        lost_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      curve_in_r <= 32'h00000000;
    end else if (upd_tick && state_r == scv_pkg::SCV_IDLE) begin
      curve_in_r <= last_valid_r;
    end
  end

  // Limits checked on the held curve input, gated by the enable
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      oor_r <= 1'b0;
    end else begin
      oor_r <= ctrl_r[`SCV_B_OOR_EN] &&
               ((curve_in_r > in_max_r) ||
                (curve_in_r < in_min_r));
    end
  end

  // Shared restoring divider, unsigned, 64 by 32
  assign rem_sh = {div_rem_r[31:0], div_quo_r[63]};
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_run_r <= 1'b0;
      div_cnt_r <= 7'h00;
      div_quo_r <= 64'h0000000000000000;
      div_rem_r <= 33'h000000000;
      div_den_r <= 32'h00000000;
    end else if (div_go) begin
      div_run_r <= 1'b1;
      div_cnt_r <= 7'h00;
      div_quo_r <= div_num;
      div_rem_r <= 33'h000000000;
      div_den_r <= div_den;
    end else if (div_run_r) begin
      if (rem_sh >= {1'b0, div_den_r}) begin
        div_rem_r <= rem_sh - {1'b0, div_den_r};
        div_quo_r <= {div_quo_r[62:0], 1'b1};
      end else begin
        div_rem_r <= rem_sh;
        div_quo_r <= {div_quo_r[62:0], 1'b0};
      end
      div_cnt_r <= div_cnt_r + 7'h01;
      div_run_r <= (div_cnt_r != 7'h3F);
    end
  end

  // Datapath terms
  always_comb begin
    f_diff   = {curve_in_r[31], curve_in_r} - {filt_r[31], filt_r};
    f_prod   = 51'(f_diff) * $signed({34'h000000000, alpha_r});
    filt_nxt = filt_r + 32'(f_prod >>> 16);
    dx       = {pt_x_r[hi_r][31], pt_x_r[hi_r]} - {pt_x_r[lo_r][31], pt_x_r[lo_r]};
    dy       = {pt_y_r[hi_r][31], pt_y_r[hi_r]} - {pt_y_r[lo_r][31], pt_y_r[lo_r]};
    xo       = {filt_r[31], filt_r} - {pt_x_r[lo_r][31], pt_x_r[lo_r]};
    ip_num   = 66'(xo) * 66'(dy);
    ip_neg   = ip_num[65];
    ip_mag   = ip_neg ? 64'(-ip_num) : ip_num[63:0];
    div_go   = (state_r == scv_pkg::SCV_ALPHA) || (state_r == scv_pkg::SCV_INTERP && dx > 0);
    if (state_r == scv_pkg::SCV_ALPHA) begin
      div_num = {16'h0000, cyc_ms, 16'h0000};
      div_den = cyc_ms + tau_r;
    end else begin
      div_num = ip_mag;
      div_den = dx[31:0];
    end
    ip_q     = ip_neg ? -div_quo_r[31:0] : div_quo_r[31:0];
  end

  // Rounding of the scaled result
  always_comb begin
    case (mode)
      scv_pkg::SCV_RND_FLOOR:   rnd_add = 32'h00000000;
      scv_pkg::SCV_RND_CEIL:    rnd_add = 32'((1 << F) - 1);
      scv_pkg::SCV_RND_NEAREST: rnd_add = 32'(1 << (F - 1));
      default:                  rnd_add = 32'h00000000;
    endcase
    rounded = interp_r + rnd_add;
    if (mode != scv_pkg::SCV_RND_FIXED) begin
      rounded[F-1:0] = '0;
    end
  end

  // Update sequence: coefficient, filter, segment search, interpolation, rounding
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r     <= scv_pkg::SCV_IDLE;
      filt_r      <= 32'h00000000;
      primed_r    <= 1'b0;
      alpha_r     <= 17'h00000;
      scan_r      <= 5'h00;
      prev_r      <= 5'h00;
      lo_r        <= 5'h00;
      hi_r        <= 5'h01;
      found_r     <= 1'b0;
      interp_r    <= 32'h00000000;
      out_r       <= 32'h00000000;
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= 1'b0;
      case (state_r)
        scv_pkg::SCV_IDLE: begin
          if (upd_tick) begin
            state_r <= ctrl_r[`SCV_B_FILT_EN] ? scv_pkg::SCV_ALPHA : scv_pkg::SCV_FILT;
          end
        end
        scv_pkg::SCV_ALPHA: state_r <= scv_pkg::SCV_ALPHA_W;
        scv_pkg::SCV_ALPHA_W: begin
          if (!div_run_r) begin
            alpha_r <= div_quo_r[16:0];
            state_r <= scv_pkg::SCV_FILT;
          end
        end
        scv_pkg::SCV_FILT: begin
          // First filtered cycle seeds from the input to avoid a ramp from zero
          if (ctrl_r[`SCV_B_FILT_EN] && primed_r) begin
            filt_r <= filt_nxt;
          end else begin
            filt_r <= curve_in_r;
          end
          primed_r <= ctrl_r[`SCV_B_FILT_EN];
          scan_r   <= 5'h01;
          prev_r   <= 5'h00;
          lo_r     <= 5'h00;
          hi_r     <= 5'h01;
          found_r  <= 1'b0;
          state_r  <= scv_pkg::SCV_SEARCH;
        end
        scv_pkg::SCV_SEARCH: begin
          // First active segment whose upper point lies above the input; else the last one
          if (used_r[scan_r]) begin
            if (!found_r) begin
              lo_r    <= prev_r;
              hi_r    <= scan_r;
              found_r <= pt_x_r[scan_r] > filt_r;
            end
            prev_r <= scan_r;
          end
          if (scan_r == 5'(NP - 1)) begin
            state_r <= scv_pkg::SCV_INTERP;
          end
          scan_r <= scan_r + 5'h01;
        end
        scv_pkg::SCV_INTERP: begin
          // Coincident points have no slope; the lower point's output is used
          if (dx > 0) begin
            state_r <= scv_pkg::SCV_INTERP_W;
          end else begin
            interp_r <= pt_y_r[lo_r];
            state_r  <= scv_pkg::SCV_ROUND;
          end
        end
        scv_pkg::SCV_INTERP_W: begin
          if (!div_run_r) begin
            interp_r <= pt_y_r[lo_r] + ip_q;
            state_r  <= scv_pkg::SCV_ROUND;
          end
        end
        scv_pkg::SCV_ROUND: begin
          out_r       <= rounded;
          out_valid_r <= 1'b1;
          state_r     <= scv_pkg::SCV_IDLE;
        end
        default: state_r <= scv_pkg::SCV_IDLE;
      endcase
    end
  end

  assign st_set[`SCV_ST_OOR]     = ctrl_r[`SCV_B_OOR_EN] && !oor_r &&
                                   ((curve_in_r > in_max_r) || (curve_in_r < in_min_r));
  assign st_set[`SCV_ST_UPDATED] = out_valid_r;
  assign st_set[`SCV_ST_LOST]    = upd_tick && lost_seen_r;

  assign rdata                      = rdata_r;
  assign curve_in                   = curve_in_r;
  assign curve_out                  = out_r;
  assign out_valid                  = out_valid_r;
  assign scaling_curve_out_of_range = oor_r;
  assign irq                        = |(status_r & irq_en_r);

  localparam int LAT_MAX = 170;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  oor_high_a: assert property (ctrl_r[1] && curve_in_r > in_max_r |=> oor_r)
    else $error("out of range missed above maximum");
  oor_low_a: assert property (ctrl_r[1] && curve_in_r < in_min_r |=> oor_r)
    else $error("out of range missed below minimum");
  oor_gate_a: assert property (!ctrl_r[1] |=> !oor_r)
    else $error("out of range flag while disabled");
  lost_hold_a: assert property (meas_lost |=> $stable(last_valid_r))
    else $error("held value changed while input lost");
  in_refresh_a: assert property (!upd_tick |=> $stable(curve_in_r))
    else $error("curve input changed off the update cycle");
  nofilt_pass_a: assert property (state_r == scv_pkg::SCV_FILT && !ctrl_r[0] |=> filt_r == $past(curve_in_r))
    else $error("filter acted while disabled");
  alpha_bound_a: assert property (state_r == scv_pkg::SCV_FILT && ctrl_r[0] |-> alpha_r <= 17'h10000)
    else $error("filter coefficient above one");
  floor_int_a: assert property (out_valid_r && $past(mode) == scv_pkg::SCV_RND_FLOOR |-> out_r <= $past(interp_r))
    else $error("floor result above the exact value");
  round_frac_a: assert property (out_valid_r && mode != scv_pkg::SCV_RND_FIXED |-> out_r[F-1:0] == '0)
    else $error("rounded output has a fraction");
  two_point_a: assert property (state_r == scv_pkg::SCV_INTERP && used_r[NP-1:2] == '0 |-> lo_r == 5'h00 && hi_r == 5'h01)
    else $error("two point line not used by default");
  done_lat_a: assert property (state_r == scv_pkg::SCV_IDLE && upd_tick |-> ##[1:LAT_MAX] out_valid_r)
    else $error("update sequence did not finish");
  read_out_a: assert property (rd && addr == `SCV_A_CURVE_OUT |=> rdata == $past(out_r))
    else $error("curve output read wrong");

  filt_run_c: cover property (state_r == scv_pkg::SCV_FILT && ctrl_r[0] && primed_r);
  oor_hit_c: cover property ($rose(oor_r));
  multi_seg_c: cover property (state_r == scv_pkg::SCV_INTERP && lo_r > 5'h01);
  lost_c: cover property (meas_lost ##1 upd_tick);
endmodule : scv_curve
`default_nettype wire

/* File: scv_meas_model.sv */
// Purpose: Measurement channel model feeding periodic milliampere samples
// Assumes: One sample strobe every PERIOD cycles
// Notes:   Data off the strobe or while lost is the inverse of the level, never a held copy
`timescale 1ns/1ps
`default_nettype none
module scv_meas_model #(
  parameter int PERIOD = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [31:0] level,
  input  wire logic        lost,
  output logic             meas_valid,
  output logic      [31:0] meas_data,
  output logic             meas_lost
);
  int cnt;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      meas_valid <= 1'b0;
      meas_data <= 32'h0;
      meas_lost <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_valid <= (cnt == 0);
      meas_lost <= lost;
      // A lost channel keeps strobing garbage so the drop path is exercised
      meas_data <= (cnt == 0 && !lost) ? level : ~level;
    end
  end
endmodule : scv_meas_model
`default_nettype wire

/* File: test_analog_input_scaling_curve.sv */
// Purpose: Self-checking bench of the scaling curve unit
// Assumes: STEP_CYCLES shortened to 10, so one update tick every 300 cycles
// Notes:   Settings change right after out_valid, before the next tick
`timescale 1ns/1ps
`default_nettype none
`include "scv_defines.svh"
module test_analog_input_scaling_curve;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [31:0] rdata, curve_in, curve_out, meas_data, level = 32'h0;
  logic        meas_valid, meas_lost, out_valid, scaling_curve_out_of_range, irq;
  logic        lost = 1'b0;
  logic [31:0] q_rd[$], q_out[$], q_oor[$];
  logic [31:0] rin[4] = '{32'h1A, 32'h1A, 32'h1A, 32'h0D};
  logic [31:0] rexp[4] = '{32'h104, 32'h100, 32'h200, 32'h100};
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 44870;

  always #5 sys_clk = ~sys_clk;

  scv_curve #(.STEP_CYCLES(10)) i_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .meas_valid(meas_valid), .meas_data(meas_data),
    .meas_lost(meas_lost), .curve_in(curve_in), .curve_out(curve_out), .out_valid(out_valid),
    .scaling_curve_out_of_range(scaling_curve_out_of_range), .irq(irq));

  scv_meas_model i_meas (.sys_clk(sys_clk), .reset(reset), .level(level), .lost(lost),
    .meas_valid(meas_valid), .meas_data(meas_data), .meas_lost(meas_lost));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    q_rd.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd_reg

  // Waits for the next result; the watcher compares it against the oldest note
  task automatic expect_next(input logic [31:0] o, input logic f);
    int n;
    n = 0;
    q_out.push_back(o);
    q_oor.push_back({31'h0, f});
    @(posedge sys_clk);
    while (out_valid !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      final_report();
    end
    #1;
  endtask : expect_next

  always @(posedge sys_clk) begin
    if (rd_q && q_rd.size() > 0) check(rdata, q_rd.pop_front());
    rd_q <= rd;
    if (out_valid === 1'b1 && q_out.size() > 0) begin
      check(curve_out, q_out.pop_front());
      check({31'h0, scaling_curve_out_of_range}, q_oor.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(`SCV_A_CTRL, 32'h0);
    rd_reg(`SCV_A_CYCLE, 32'h1E);
    rd_reg(`SCV_A_TAU, 32'h3E8);
    rd_reg(`SCV_A_PT_X + 8'h04, 32'h100);
    rd_reg(`SCV_A_PT_USED, 32'h0);
    rd_reg(8'hFC, 32'h0);
    wr_reg(`SCV_A_PT_Y + 8'h04, 32'hA00);
    level <= 32'h80;
    // Point two output is written well before the first tick, so the first result is already scaled
    expect_next(32'h500, 1'b0);
    q_out.delete();
    q_oor.delete();
    expect_next(32'h500, 1'b0);
    check(curve_in, 32'h80);
    rd_reg(`SCV_A_CURVE_IN, 32'h80);
    rd_reg(`SCV_A_CURVE_OUT, 32'h500);
    for (int m = 0; m < 4; m++) begin
      wr_reg(`SCV_A_CTRL, {28'h0, scv_pkg::scv_mode_t'(m), 2'b00});
      level <= rin[m];
      expect_next(rexp[m], 1'b0);
    end
    wr_reg(`SCV_A_CTRL, 32'h0);
    wr_reg(`SCV_A_PT_X + 8'h08, 32'h200);
    wr_reg(`SCV_A_PT_Y + 8'h08, 32'hA00);
    wr_reg(`SCV_A_PT_USED, 32'h4);
    level <= 32'h180;
    expect_next(32'hA00, 1'b0);
    wr_reg(`SCV_A_PT_USED, 32'h0);
    expect_next(32'hF00, 1'b0);
    for (int i = 0; i < 3; i++) begin
      level <= $random(seed) & 32'hFF;
      #1;
      expect_next(level * 10, 1'b0);
    end
    wr_reg(`SCV_A_IN_MIN, 32'h40);
    wr_reg(`SCV_A_IN_MAX, 32'h300);
    wr_reg(`SCV_A_IRQ_EN, 32'h1);
    level <= 32'h400;
    expect_next(32'h2800, 1'b0);
    wr_reg(`SCV_A_CTRL, 32'h2);
    expect_next(32'h2800, 1'b1);
    check({31'h0, irq}, 32'h1);
    rd_reg(`SCV_A_STATUS, 32'h3);
    wr_reg(`SCV_A_CLEAR, 32'h1);
    level <= 32'h20;
    expect_next(32'h140, 1'b1);
    check({31'h0, irq}, 32'h0);
    level <= 32'h100;
    expect_next(32'hA00, 1'b0);
    wr_reg(`SCV_A_CTRL, 32'h0);
    level <= 32'h80;
    expect_next(32'h500, 1'b0);
    lost <= 1'b1;
    level <= 32'h300;
    expect_next(32'h500, 1'b0);
    expect_next(32'h500, 1'b0);
    lost <= 1'b0;
    expect_next(32'h1E00, 1'b0);
    // Time constant equal to the cycle gives a coefficient of one half
    wr_reg(`SCV_A_TAU, 32'd150);
    wr_reg(`SCV_A_PT_Y + 8'h04, 32'h100);
    level <= 32'h0;
    expect_next(32'h0, 1'b0);
    wr_reg(`SCV_A_CTRL, 32'h1);
    expect_next(32'h0, 1'b0);
    level <= 32'h400;
    expect_next(32'h200, 1'b0);
    expect_next(32'h300, 1'b0);
    wr_reg(`SCV_A_CTRL, 32'h0);
    expect_next(32'h400, 1'b0);
    final_report();
  end
endmodule : test_analog_input_scaling_curve
`default_nettype wire
